// ===== rtl/ssl_pkg.sv
`default_nettype none
package ssl_pkg;
    // ==========================================
    // serial word and steering codes
    localparam int WORD_W = 24;
    localparam logic [1:0] STEER_CONFIG = 2'b00;
    localparam logic [1:0] STEER_REFERENCE = 2'b01;
    localparam logic [1:0] STEER_FEEDBACK = 2'b10;

    // ==========================================
    // reset contents of the three latches
    localparam logic [23:0] CONFIG_RST = 24'h00_0000;
    localparam logic [23:0] FEEDBACK_RST = 24'h00_0000;
    localparam logic [23:0] REFERENCE_RST = 24'h00_0000;
    localparam logic GAIN_RST = 1'b0;

    // ==========================================
    // lock detector and dividers
    localparam logic [2:0] LOCK_CYCLES_FINE = 3'h5;
    localparam logic [2:0] LOCK_CYCLES_COARSE = 3'h3;
    localparam int PHASE_ERR_NS = 15;
    localparam logic [17:0] PRESCALE_8 = 18'h0_0008;
    localparam logic [17:0] PRESCALE_16 = 18'h0_0010;
    localparam logic [17:0] PRESCALE_32 = 18'h0_0020;

    // ==========================================
    // pin sampling: bit positions in the synchroniser vector
    localparam int PIN_N = 5;
    localparam int PIN_SER_CLK = 0;
    localparam int PIN_SER_DATA = 1;
    localparam int PIN_LOAD = 2;
    localparam int PIN_REF_CLK = 3;
    localparam int PIN_PHASE_OK = 4;

    // ==========================================
    // latch layouts, msb first, 24 bits each
    typedef struct packed {
        logic [1:0] prescaler_sel;
        logic [1:0] power_down;
        logic [2:0] pump_current_second;
        logic [2:0] pump_current_first;
        logic [1:0] output_power_level;
        logic mute_till_lock;
        logic pump_gain_flag;
        logic pump_tristate;
        logic phase_polarity_sel;
        logic [2:0] out_mux_sel;
        logic counter_reset;
        logic [1:0] core_power_level;
        logic [1:0] latch_steer_bits;
    } ssl_config_t;

    typedef struct packed {
        logic halved_prescale_sel;
        logic halved_out_en;
        logic pump_gain_flag;
        logic [12:0] main_count;
        logic spare_bit;
        logic [4:0] swallow_count;
        logic [1:0] latch_steer_bits;
    } ssl_feedback_t;

    typedef struct packed {
        logic [1:0] spare_bit;
        logic [1:0] band_clk_div;
        logic factory_test_en;
        logic lock_precision_sel;
        logic [1:0] antibacklash_width;
        logic [13:0] ref_ratio;
        logic [1:0] latch_steer_bits;
    } ssl_reference_t;
endpackage
`default_nettype wire

// ===== rtl/ssl_sync.sv
`default_nettype none
module ssl_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;
endmodule
`default_nettype wire

// ===== rtl/ssl_lock_det.sv
`default_nettype none
module ssl_lock_det (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic clear_i,
    input wire logic ref_tick_i,
    input wire logic phase_ok_i,
    input wire logic precision_i,
    output logic locked_o
);
    logic [2:0] run_r;
    logic [2:0] run_nxt;
    logic locked_r;
    logic locked_nxt;
    logic [2:0] target;

    always_comb begin
        target = precision_i ? ssl_pkg::LOCK_CYCLES_FINE : ssl_pkg::LOCK_CYCLES_COARSE; // R18
        run_nxt = run_r;
        locked_nxt = locked_r;
        if (clear_i) begin
            run_nxt = 3'h0;
            locked_nxt = 1'b0;
        end else if (ref_tick_i) begin
            if (phase_ok_i) begin
                // saturate so a long lock never wraps
                if (run_r < 3'h7) begin
                    run_nxt = run_r + 3'h1;
                end
                // widened: a saturated count of 7 must not wrap to 0 and drop lock
                locked_nxt = ({1'b0, run_r} + 4'h1) >= {1'b0, target}; // R18
            end else begin
                run_nxt = 3'h0;
                locked_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            run_r <= 3'h0;
            locked_r <= 1'b0;
        end else begin
            run_r <= run_nxt;
            locked_r <= locked_nxt;
        end
    end

    assign locked_o = locked_r;
endmodule
`default_nettype wire

// ===== rtl/ssl_latch_bank.sv
// Summary of operation
// R1 - two 3-bit pump currents; gain flag 1 picks second, 0 picks first
// R2 - with mute-till-lock set, rf outputs stay off until lock
// R3 - pump tristate bit 1 puts the charge pump in three-state
// R4 - phase polarity 1 positive, 0 negative
// R5 - counter reset bit 1 holds reference, A and B counters in reset
// R6 - config word carries mux select, output power and core power fields
// R7 - steering 1,0 loads the feedback divider word on strobe
// R8 - steering 0,1 loads the reference divider word on strobe
// R9 - 5-bit swallow count, 0 to 31
// R10 - host writes spare bits as zero
// R11 - 13-bit main count, valid 3 to 8191
// R12 - total division is prescaler times main count plus swallow count
// R13 - gain flag shared by two words; last write wins
// R14 - halved output enable bit 22 of feedback word
// R15 - bit 23 feeds halved output into prescaler
// R16 - 14-bit reference ratio, valid 1 to 16383
// R17 - bits 16 and 17 select antibacklash width
// R18 - lock after five good cycles if precision set, else three
// R19 - factory test bit kept zero; user latches rule operation
// R20 - band clock field divides reference counter output for band logic
// R21 - shift one bit per rising serial clock; load last 24 on strobe
// R22 - host keeps serial clock at or below 20 MHz; this block samples at 25 MHz and needs 6.25 MHz or less
// R23 - steering 0,0 loads the config word on strobe
// R24 - host programs reference, then config, then feedback word
// R25 - strobe low while shifting, msb first, steering bits last
// R26 - shifting without a strobe edge changes no latch
`default_nettype none
module ssl_latch_bank (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ser_clk_i,
    input wire logic ser_data_i,
    input wire logic load_strobe_i,
    input wire logic ref_clk_i,
    input wire logic phase_ok_i,
    output ssl_pkg::ssl_config_t config_o,
    output ssl_pkg::ssl_feedback_t feedback_o,
    output ssl_pkg::ssl_reference_t reference_o,
    output logic pump_gain_flag_o,
    output logic [2:0] pump_current_o,
    output logic pump_tristate_o,
    output logic phase_polarity_o,
    output logic counter_reset_o,
    output logic rf_out_en_o,
    output logic locked_o,
    output logic [17:0] feedback_ratio_o,
    output logic ref_tick_o,
    output logic band_tick_o,
    output logic factory_test_o
);
    // ==========================================
    // pin sampling
    logic [ssl_pkg::PIN_N-1:0] pins_async;
    logic [ssl_pkg::PIN_N-1:0] pins;

    assign pins_async[ssl_pkg::PIN_SER_CLK] = ser_clk_i;
    assign pins_async[ssl_pkg::PIN_SER_DATA] = ser_data_i;
    assign pins_async[ssl_pkg::PIN_LOAD] = load_strobe_i;
    assign pins_async[ssl_pkg::PIN_REF_CLK] = ref_clk_i;
    assign pins_async[ssl_pkg::PIN_PHASE_OK] = phase_ok_i;

    // oversampled at 25 MHz: each serial clock level must last two system clocks
    // limitation: a level shorter than two clocks can vanish unseen
    // phase_ok shares the delay of ref_clk, keeping it aligned to its tick
    ssl_sync #(
        .W(ssl_pkg::PIN_N)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .async_i(pins_async),
        .sync_o(pins)
    );

    // ==========================================
    // edge detection on synchronised levels
    // detectors reset low, the idle level of all three pins: no false edge
    logic sclk_d_r;
    logic load_d_r;
    logic ref_d_r;
    logic sclk_rise;
    logic load_rise;
    logic ref_rise;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            sclk_d_r <= 1'b0;
            load_d_r <= 1'b0;
            ref_d_r <= 1'b0;
        end else begin
            sclk_d_r <= pins[ssl_pkg::PIN_SER_CLK];
            load_d_r <= pins[ssl_pkg::PIN_LOAD];
            ref_d_r <= pins[ssl_pkg::PIN_REF_CLK];
        end
    end

    assign sclk_rise = pins[ssl_pkg::PIN_SER_CLK] & ~sclk_d_r;
    assign load_rise = pins[ssl_pkg::PIN_LOAD] & ~load_d_r;
    assign ref_rise = pins[ssl_pkg::PIN_REF_CLK] & ~ref_d_r;

    // ==========================================
    // shift register and latches
    // the input register shifts in any state; only the strobe moves words
    logic [23:0] shift_r;
    logic [23:0] shift_nxt;
    ssl_pkg::ssl_config_t cfg_r;
    ssl_pkg::ssl_config_t cfg_nxt;
    ssl_pkg::ssl_feedback_t fbk_r;
    ssl_pkg::ssl_feedback_t fbk_nxt;
    ssl_pkg::ssl_reference_t ref_r;
    ssl_pkg::ssl_reference_t ref_nxt;
    logic gain_r;
    logic gain_nxt;
    ssl_pkg::ssl_config_t shift_as_cfg;
    ssl_pkg::ssl_feedback_t shift_as_fbk;

    assign shift_as_cfg = ssl_pkg::ssl_config_t'(shift_r);
    assign shift_as_fbk = ssl_pkg::ssl_feedback_t'(shift_r);

    always_comb begin
        shift_nxt = shift_r;
        cfg_nxt = cfg_r;
        fbk_nxt = fbk_r;
        ref_nxt = ref_r;
        gain_nxt = gain_r;
        // msb arrives first, so steering bits end up in [1:0]
        if (sclk_rise) begin
            shift_nxt = {shift_r[22:0], pins[ssl_pkg::PIN_SER_DATA]}; // R21 R25
        end
        // latches change only here, on the strobe edge
        // a short word mixes with older bits; the host sends all 24
        if (load_rise) begin // R21 R26
            // shared gain flag: whichever word loads last owns it
            case (shift_r[1:0])
                ssl_pkg::STEER_CONFIG: begin
                    cfg_nxt = shift_as_cfg; // R23 R6
                    gain_nxt = shift_as_cfg.pump_gain_flag; // R13
                end
                ssl_pkg::STEER_FEEDBACK: begin
                    fbk_nxt = shift_as_fbk; // R7 R9 R11 R14 R15
                    gain_nxt = shift_as_fbk.pump_gain_flag; // R13
                end
                ssl_pkg::STEER_REFERENCE: begin
                    ref_nxt = ssl_pkg::ssl_reference_t'(shift_r); // R8 R16 R17
                end
                // factory test latch: not kept, word dropped
                default: begin
                    ref_nxt = ref_r; // R19
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            shift_r <= 24'h00_0000;
            cfg_r <= ssl_pkg::ssl_config_t'(ssl_pkg::CONFIG_RST);
            fbk_r <= ssl_pkg::ssl_feedback_t'(ssl_pkg::FEEDBACK_RST);
            ref_r <= ssl_pkg::ssl_reference_t'(ssl_pkg::REFERENCE_RST);
            gain_r <= ssl_pkg::GAIN_RST;
        end else begin
            shift_r <= shift_nxt;
            cfg_r <= cfg_nxt;
            fbk_r <= fbk_nxt;
            ref_r <= ref_nxt;
            gain_r <= gain_nxt;
        end
    end

    // ==========================================
    // reference counter and band select divider
    // counter reset is a level hold, so it wins over a pending edge
    // mask 0/1/3/7 gives one band tick per 1/2/4/8 reference ticks
    logic [13:0] rcnt_r;
    logic [13:0] rcnt_nxt;
    logic rtick_r;
    logic rtick_nxt;
    logic [2:0] bcnt_r;
    logic [2:0] bcnt_nxt;
    logic btick_r;
    logic btick_nxt;
    logic [2:0] bmask;
    logic [13:0] rlast;

    always_comb begin
        // a ratio of zero behaves as one
        rlast = (ref_r.ref_ratio == 14'h0000) ? 14'h0000 : ref_r.ref_ratio - 14'h0001; // R16
        case (ref_r.band_clk_div)
            2'h0: bmask = 3'h0;
            2'h1: bmask = 3'h1;
            2'h2: bmask = 3'h3;
            default: bmask = 3'h7;
        endcase
        rcnt_nxt = rcnt_r;
        rtick_nxt = 1'b0;
        bcnt_nxt = bcnt_r;
        btick_nxt = 1'b0;
        if (cfg_r.counter_reset) begin
            rcnt_nxt = 14'h0000; // R5
            bcnt_nxt = 3'h0;
        end else begin
            if (ref_rise) begin
                if (rcnt_r >= rlast) begin
                    rcnt_nxt = 14'h0000;
                    rtick_nxt = 1'b1;
                end else begin
                    rcnt_nxt = rcnt_r + 14'h0001;
                end
            end
            if (rtick_r) begin
                if ((bcnt_r & bmask) == bmask) begin
                    bcnt_nxt = 3'h0;
                    btick_nxt = 1'b1; // R20
                end else begin
                    bcnt_nxt = bcnt_r + 3'h1; // R20
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rcnt_r <= 14'h0000;
            rtick_r <= 1'b0;
            bcnt_r <= 3'h0;
            btick_r <= 1'b0;
        end else begin
            rcnt_r <= rcnt_nxt;
            rtick_r <= rtick_nxt;
            bcnt_r <= bcnt_nxt;
            btick_r <= btick_nxt;
        end
    end

    // ==========================================
    // lock detector
    logic locked;

    // phase_ok sampled with the tick it belongs to
    // counter reset doubles as lock clear; a stale lock must not survive it
    ssl_lock_det u_lock (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .clear_i(cfg_r.counter_reset),
        .ref_tick_i(rtick_r),
        .phase_ok_i(pins[ssl_pkg::PIN_PHASE_OK]),
        .precision_i(ref_r.lock_precision_sel),
        .locked_o(locked)
    );

    // ==========================================
    // derived outputs, all registered
    // one clock behind the latches; registers keep glitches off the outputs
    logic [17:0] modulus;
    logic [17:0] ratio_nxt;
    logic [17:0] ratio_r;
    logic [2:0] cur_nxt;
    logic [2:0] cur_r;
    logic rf_en_nxt;
    logic rf_en_r;

    always_comb begin
        // codes 2 and 3 both select modulus 32
        case (cfg_r.prescaler_sel)
            2'h0: modulus = ssl_pkg::PRESCALE_8;
            2'h1: modulus = ssl_pkg::PRESCALE_16;
            default: modulus = ssl_pkg::PRESCALE_32;
        endcase
        // largest ratio 32 x 8191 + 31 still fits 18 bits
        ratio_nxt = 18'(modulus * {5'h00, fbk_r.main_count}) + {13'h0000, fbk_r.swallow_count}; // R12
        cur_nxt = gain_r ? cfg_r.pump_current_second : cfg_r.pump_current_first; // R1 R13
        // with mute off the outputs run even while unlocked
        rf_en_nxt = ~(cfg_r.mute_till_lock & ~locked); // R2
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ratio_r <= 18'h0_0000;
            cur_r <= 3'h0;
            rf_en_r <= 1'b0;
        end else begin
            ratio_r <= ratio_nxt;
            cur_r <= cur_nxt;
            rf_en_r <= rf_en_nxt;
        end
    end

    // whole latches leave the block, next to the decoded pump, ratio, rf and config bit outputs
    assign config_o = cfg_r;
    assign feedback_o = fbk_r;
    assign reference_o = ref_r;
    assign pump_gain_flag_o = gain_r;
    assign pump_current_o = cur_r;
    assign pump_tristate_o = cfg_r.pump_tristate; // R3
    assign phase_polarity_o = cfg_r.phase_polarity_sel; // R4
    assign counter_reset_o = cfg_r.counter_reset; // R5
    assign rf_out_en_o = rf_en_r;
    assign locked_o = locked;
    assign feedback_ratio_o = ratio_r;
    assign ref_tick_o = rtick_r;
    assign band_tick_o = btick_r;
    assign factory_test_o = ref_r.factory_test_en;
endmodule
`default_nettype wire

// ===== tb/ssl_host.sv
`default_nettype none
module ssl_host (
    input wire logic clk_i,
    output logic ser_clk_o,
    output logic ser_data_o,
    output logic load_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ser_clk_o = 1'b0;
        ser_data_o = 1'b1;
        load_o = 1'b0;
    end

    // ==========================================
    // one frame; call at a falling clock edge
    // 6 clk per bit keeps the serial clock far below its ceiling
    task automatic send(input logic [23:0] word, input logic ld);
        for (int i = 23; i >= 0; i--) begin
            ser_clk_o = 1'b0;
            ser_data_o = word[i];
            repeat (3) @(negedge clk_i);
            ser_clk_o = 1'b1;
            repeat (3) @(negedge clk_i);
        end
        ser_clk_o = 1'b0;
        // released data line must not keep the last bit
        ser_data_o = ~word[0];
        repeat (3) @(negedge clk_i);
        load_o = ld;
        repeat (4) @(negedge clk_i);
        load_o = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// ===== tb/ssl_latch_bank_asserts.sv
`default_nettype none
module ssl_latch_bank_asserts (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic load_strobe_i,
    input wire ssl_pkg::ssl_config_t config_o,
    input wire ssl_pkg::ssl_feedback_t feedback_o,
    input wire ssl_pkg::ssl_reference_t reference_o,
    input wire logic pump_gain_flag_o,
    input wire logic [2:0] pump_current_o,
    input wire logic pump_tristate_o,
    input wire logic phase_polarity_o,
    input wire logic counter_reset_o,
    input wire logic rf_out_en_o,
    input wire logic locked_o,
    input wire logic [17:0] feedback_ratio_o,
    input wire logic ref_tick_o,
    input wire logic band_tick_o,
    input wire logic factory_test_o
);
    logic [17:0] modulus;
    logic [17:0] ratio_exp;
    assign modulus = (config_o.prescaler_sel == 2'h0) ? ssl_pkg::PRESCALE_8 :
        (config_o.prescaler_sel == 2'h1) ? ssl_pkg::PRESCALE_16 : ssl_pkg::PRESCALE_32;
    assign ratio_exp = modulus * {5'h0, feedback_o.main_count} + {13'h0, feedback_o.swallow_count};

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    // ==========================================
    // derived outputs
    chk_pump_select: assert property ($stable(config_o) && $stable(pump_gain_flag_o) |-> pump_current_o ==
        (pump_gain_flag_o ? config_o.pump_current_second : config_o.pump_current_first))
        else $error("pump current does not follow gain flag");
    chk_rf_mute: assert property ((config_o.mute_till_lock && !locked_o) [*2] |-> !rf_out_en_o)
        else $error("rf output on before lock");
    chk_cfg_bits: assert property ($stable(config_o) |-> pump_tristate_o == config_o.pump_tristate &&
        phase_polarity_o == config_o.phase_polarity_sel && counter_reset_o == config_o.counter_reset)
        else $error("config bit outputs disagree with latch");
    chk_ratio_calc: assert property ($stable(config_o) && $stable(feedback_o) |-> feedback_ratio_o == ratio_exp)
        else $error("feedback ratio wrong");
    chk_gain_alias: assert property ($changed(config_o) |-> ##[0:1] pump_gain_flag_o == config_o.pump_gain_flag)
        else $error("gain flag missed config write");
    chk_gain_feedback: assert property ($changed(feedback_o) |-> pump_gain_flag_o == feedback_o.pump_gain_flag)
        else $error("gain flag missed feedback write");
    chk_counter_hold: assert property (config_o.counter_reset [*4] |-> !ref_tick_o && !band_tick_o && !locked_o)
        else $error("counters run during counter reset");
    chk_band_follow: assert property (band_tick_o |-> $past(ref_tick_o))
        else $error("band tick without reference tick");
    chk_test_bit: assert property ($stable(reference_o) |-> factory_test_o == reference_o.factory_test_en)
        else $error("factory test output wrong");

    // ==========================================
    // latch loading
    chk_steer_match: assert property ((!$changed(config_o) || config_o.latch_steer_bits == ssl_pkg::STEER_CONFIG) &&
        (!$changed(feedback_o) || feedback_o.latch_steer_bits == ssl_pkg::STEER_FEEDBACK) &&
        (!$changed(reference_o) || reference_o.latch_steer_bits == ssl_pkg::STEER_REFERENCE))
        else $error("latch loaded with foreign steering");
    chk_strobe_cause: assert property ($changed(config_o) || $changed(feedback_o) || $changed(reference_o) |->
        $past(load_strobe_i, 3) || $past(load_strobe_i, 4))
        else $error("latch changed without strobe");
endmodule

bind ssl_latch_bank ssl_latch_bank_asserts u_chk (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .load_strobe_i(load_strobe_i), .config_o(config_o),
    .feedback_o(feedback_o), .reference_o(reference_o), .pump_gain_flag_o(pump_gain_flag_o),
    .pump_current_o(pump_current_o), .pump_tristate_o(pump_tristate_o), .phase_polarity_o(phase_polarity_o),
    .counter_reset_o(counter_reset_o), .rf_out_en_o(rf_out_en_o), .locked_o(locked_o),
    .feedback_ratio_o(feedback_ratio_o), .ref_tick_o(ref_tick_o), .band_tick_o(band_tick_o),
    .factory_test_o(factory_test_o)
);
`default_nettype wire

// ===== tb/ssl_latch_bank_tb.sv
`default_nettype none
module ssl_latch_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ref_clk = 1'b0;
    logic phase_ok = 1'b0;
    logic ref_run = 1'b0;
    logic ser_clk, ser_data, load;
    ssl_pkg::ssl_config_t cfg_q;
    ssl_pkg::ssl_feedback_t fb_q;
    ssl_pkg::ssl_reference_t ref_q;
    logic pump_gain_flag, pump_tristate, phase_polarity, counter_reset, rf_out_en;
    logic locked, ref_tick, band_tick, factory_test;
    logic [2:0] pump_current;
    logic [17:0] feedback_ratio;
    logic [23:0] saved [3];
    int bad_count = 0;
    int n_tests = 0;
    int n_tick;
    int n_band;

    always #20 clk_sys_i = ~clk_sys_i;

    // reference clock idles low; one period is 8 system clocks
    always begin
        repeat (4) @(negedge clk_sys_i);
        ref_clk = ref_run ? ~ref_clk : 1'b0;
    end

    ssl_host host (.clk_i(clk_sys_i), .ser_clk_o(ser_clk), .ser_data_o(ser_data), .load_o(load));

    ssl_latch_bank dut (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ser_clk_i(ser_clk), .ser_data_i(ser_data),
        .load_strobe_i(load), .ref_clk_i(ref_clk), .phase_ok_i(phase_ok), .config_o(cfg_q),
        .feedback_o(fb_q), .reference_o(ref_q), .pump_gain_flag_o(pump_gain_flag),
        .pump_current_o(pump_current), .pump_tristate_o(pump_tristate), .phase_polarity_o(phase_polarity),
        .counter_reset_o(counter_reset), .rf_out_en_o(rf_out_en), .locked_o(locked),
        .feedback_ratio_o(feedback_ratio), .ref_tick_o(ref_tick), .band_tick_o(band_tick),
        .factory_test_o(factory_test)
    );

    // ==========================================
    // shared tasks
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // derived outputs settle one edge after the latch
    task automatic wr(input logic [23:0] w);
        host.send(w, 1'b1);
        repeat (3) @(negedge clk_sys_i);
    endtask

    task automatic lock_run(input logic [23:0] exp, input logic [23:0] band_exp);
        n_tick = 0;
        n_band = 0;
        ref_run = 1'b1;
        for (int i = 0; i < 400 && !locked; i++) begin
            @(negedge clk_sys_i);
            if (ref_tick) n_tick++;
            if (band_tick) n_band++;
        end
        check("ticks to lock", exp, n_tick);
        check("band ticks", band_exp, n_band);
        repeat (2) @(negedge clk_sys_i);
        check("rf on after lock", 1, rf_out_en);
        ref_run = 1'b0;
    endtask

    // ==========================================
    // sequence
    initial begin
        repeat (2) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        // spare and test bits written as zero
        wr(24'h160009);
        check("reference", 24'h160009, ref_q);
        check("factory test", 0, factory_test);
        wr(24'h4aeb68);
        check("config", 24'h4aeb68, cfg_q);
        check("pump current", 3'h3, pump_current);
        check("tristate", 1, pump_tristate);
        check("polarity", 1, phase_polarity);
        check("rf muted", 0, rf_out_en);
        // minimum main count, maximum swallow count, gain set
        wr(24'he0037e);
        check("feedback", 24'he0037e, fb_q);
        check("gain via feedback", 1, pump_gain_flag);
        check("pump current second", 3'h5, pump_current);
        check("ratio", ssl_pkg::PRESCALE_16 * 3 + 31, feedback_ratio);
        saved = '{cfg_q, fb_q, ref_q};
        host.send(24'hffffff, 1'b1);
        host.send(24'h000000, 1'b0);
        repeat (3) @(negedge clk_sys_i);
        check("config kept", saved[0], cfg_q);
        check("feedback kept", saved[1], fb_q);
        check("reference kept", saved[2], ref_q);
        for (int p = 0; p < 4; p++) begin
            wr({p[1:0], 22'h0aeb68});
            check("ratio", (p == 0 ? ssl_pkg::PRESCALE_8 : p == 1 ? ssl_pkg::PRESCALE_16 :
                ssl_pkg::PRESCALE_32) * 3 + 31, feedback_ratio);
        end
        check("gain via config", 0, pump_gain_flag);
        phase_ok = 1'b1;
        lock_run(5, 2);
        // precision off, band divider off
        wr(24'h020009);
        check("reference band 0", 24'h020009, ref_q);
        wr(24'h4aeb78);
        check("counter reset", 1, counter_reset);
        check("lock cleared", 0, locked);
        wr(24'h4aeb68);
        lock_run(3, 3);
        // reset in mid-run: latches and lock back to reset values
        resetn_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        check("rf off in reset", 0, rf_out_en);
        check("config reset", ssl_pkg::CONFIG_RST, cfg_q);
        check("feedback reset", ssl_pkg::FEEDBACK_RST, fb_q);
        check("reference reset", ssl_pkg::REFERENCE_RST, ref_q);
        check("gain reset", ssl_pkg::GAIN_RST, pump_gain_flag);
        check("lock reset", 0, locked);
        resetn_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        check("rf on after reset", 1, rf_out_en);
        wr(24'h4aeb68);
        check("config after reset", 24'h4aeb68, cfg_q);
        print_verdict;
    end

    // 13 frames of about 155 clocks plus two lock runs fit well inside this
    initial begin
        #400000;
        bad_count++;
        $display("[FAIL] watchdog expected done seen hang");
        print_verdict;
    end
endmodule
`default_nettype wire
